// file: bench/host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the record port: one byte per clock, strobe held until idle or abort
module host_model (
    input  wire logic       clk,       // Module clock
    output logic            rec_wr,    // Byte write strobe
    output logic [3:0]      rec_idx,   // Byte position
    output logic [7:0]      rec_byte,  // Byte value
    output logic            rec_abort  // Drop partial record
);
    // Quiet port at time zero
    initial begin
        rec_wr    = 1'b0;
        rec_idx   = 4'h0;
        rec_byte  = 8'h00;
        rec_abort = 1'b0;
    end
    // One write; back to back calls keep the strobe high
    task automatic wr(input logic [3:0] idx, input logic [7:0] b);
        @(posedge clk);
        rec_wr   <= 1'b1;
        rec_idx  <= idx;
        rec_byte <= b;
    endtask
    // Release: data goes stale so a late sample cannot look valid
    task automatic idle();
        @(posedge clk);
        rec_wr   <= 1'b0;
        rec_byte <= ~rec_byte;
    endtask
    // Abort pulse drops whatever part of a record is pending
    task automatic abort();
        @(posedge clk);
        rec_wr    <= 1'b0;  // A held strobe would rewrite the last byte after the abort
        rec_abort <= 1'b1;
        @(posedge clk);
        rec_abort <= 1'b0;
    endtask
endmodule // host_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import aiparam_pkg::*;
    logic             clk = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0;
    logic [3:0]       rd_idx = 4'h0;
    sample_t          sample = '0;
    logic             rec_wr, rec_abort, rec_ready, rec_done, rec_err;
    logic             integ_short, conv_start, value_upd;
    logic [3:0]       rec_idx;
    logic [7:0]       rec_byte, rd_byte, cfg_err, conv_en;
    temp_unit_t       temp_unit;
    chan_cfg_t [7:0]  chan_cfg;
    logic [7:0][15:0] value_word;
    int               err_count = 0, tests_run = 0;
    logic [7:0]       rec [14];                  // Model of the applied record
    logic [15:0]      last [8] = '{default: '0}; // Model of the value words
    // Last two: an unsupported voltage range, then a table type
    logic [7:0]       modes [15] = '{8'h1b, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19,
                                     8'h22, 8'h23, 8'h24, 8'h52, 8'h53, 8'h00, 8'h15, 8'h92};
    int               raws [9] = '{27648, 32511, 32512, -32512, -32513, -4864, -4865, -1, 0};
    always #4 clk = ~clk;
    host_model u_host (.clk(clk), .rec_wr(rec_wr), .rec_idx(rec_idx), .rec_byte(rec_byte),
                       .rec_abort(rec_abort));
    // Short windows keep the run brief
    analog_input_param_record #(.INT_SHORT_CYC(20), .INT_LONG_CYC(24)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .rec_wr(rec_wr), .rec_idx(rec_idx),
        .rec_byte(rec_byte), .rec_abort(rec_abort), .rec_ready(rec_ready),
        .rec_done(rec_done), .rec_err(rec_err), .rd_idx(rd_idx), .rd_byte(rd_byte),
        .temp_unit(temp_unit), .integ_short(integ_short), .chan_cfg(chan_cfg),
        .cfg_err(cfg_err), .conv_start(conv_start), .conv_en(conv_en),
        .sample_valid(sample_valid), .sample(sample), .value_word(value_word),
        .value_upd(value_upd));
    ////////////////////////////////////////////////////////////////////////////
    // Range class: 1 bipolar, 2 unipolar, 3 resistance, 4 table type, 0 off or unsupported
    function automatic int cls_of(logic [7:0] m);
        if (m[7:4] == 4'h1 && m[3:0] inside {4'hb, 4'h3, 4'h4, 4'h6, 4'h9}) return 1;
        if (m == 8'h24) return 1;
        if (m inside {8'h17, 8'h18, 8'h22, 8'h23}) return 2;
        if (m inside {8'h52, 8'h53}) return 3;
        return m[7:4] == 4'h9 ? 4 : 0;
    endfunction
    // Expected word from the range class
    function automatic logic [15:0] exp_word(logic [7:0] m, int r);
        int c;
        c = cls_of(m);
        if (r > (c == 4 ? 32767 : 32511)) return 16'h7fff;
        if (c == 3 && r < 0) return 16'h0000;
        if (r < (c == 1 ? -32512 : c == 2 ? -4864 : -32768)) return 16'h8000;
        return r[15:0] & 16'hfff8;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Decoded settings and readback against the record model
    task automatic check_cfg();
        logic [7:0] bad;
        bad = 8'h00;
        for (int i = 0; i < 8; i++) begin
            chk(16'(chan_cfg[i]), {4'h0, rec[2+i], i[0] ? rec[10+i/2][3:0] : rec[10+i/2][7:4]});
            chk(16'(conv_en[i]), 16'(cls_of(rec[2+i]) != 0));
            bad[i] = rec[2+i] != 8'h00 && cls_of(rec[2+i]) == 0;
        end
        chk(16'(cfg_err), 16'(bad));
        chk(16'(temp_unit), rec[0] == 8'h08 ? 16'h1 : rec[0] == 8'h10 ? 16'h2 :
                            rec[0] == 8'h00 ? 16'h0 : 16'h3);
        chk(16'(integ_short), 16'(rec[1] == 8'h01));
        for (int i = 0; i < 15; i++) begin
            @(posedge clk) rd_idx <= 4'(i);
            @(posedge clk) #1 chk(16'(rd_byte), i < 14 ? 16'(rec[i]) : 16'h0);
        end
    endtask
    // Full record, then wait a bounded time for the apply pulse
    task automatic load();
        for (int i = 0; i < 14; i++) u_host.wr(4'(i), rec[i]);
        u_host.idle();
        // The last byte has just been taken: the port is closed for the apply cycle
        #1 chk(16'(rec_ready), 16'h0);
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            #1;
            if (rec_done === 1'b1) break;
        end
        chk(16'(rec_done), 16'h1);
    endtask
    // Gap between two window starts
    task automatic period(input int exp);
        int n;
        n = 0;
        while (conv_start !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
        n = 0;
        do begin @(posedge clk); #1; n++; end while (conv_start !== 1'b1 && n < 100);
        chk(16'(n), 16'(exp));
    endtask
    // One sample; disabled channels must keep their old word
    task automatic put(input logic [2:0] ch, input int r);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample       <= {ch, 17'(r)};
        @(posedge clk);
        sample_valid <= 1'b0;
        // The update pulse stands for the one cycle after the scaler's result
        @(posedge clk);
        #1;
        if (cls_of(rec[2+ch]) != 0) last[ch] = exp_word(rec[2+ch], r);
        chk(value_word[ch], last[ch]);
        chk(16'(value_upd), 16'(cls_of(rec[2+ch]) != 0));
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h238e_e7f6));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rec[i]) rec[i] = (i == 1) ? 8'h02 : (i >= 2 && i <= 9) ? 8'h19 : 8'h00;
        @(posedge clk) #1;
        check_cfg();
        period(24);
        $display("test defaults done");
        // Partial record then abort: nothing may change
        for (int i = 0; i < 13; i++) u_host.wr(4'(i), modes[i]);
        u_host.abort();
        u_host.wr(4'hd, 8'h00);
        u_host.wr(4'he, 8'h55);
        u_host.idle();
        #1 chk(16'(rec_err), 16'h1);
        // Drop the lone pending byte so the next record needs all fourteen
        u_host.abort();
        repeat (3) @(posedge clk);
        #1 chk(16'(chan_cfg[0]), 16'h0190);
        $display("test abort done");
        for (int k = 0; k < 3; k++) begin
            // Third record carries an unsupported unit code
            rec[0] = k == 0 ? 8'h08 : k == 1 ? 8'h10 : 8'h20;
            rec[1] = k == 1 ? 8'h01 : 8'h02;
            for (int i = 0; i < 8; i++) rec[2+i] = modes[(k * 8 + i) % 15];
            for (int i = 10; i < 14; i++) rec[i] = 8'($urandom);
            load();
            check_cfg();
            period(k == 1 ? 20 : 24);
            raws[8] = int'($urandom_range(131071)) - 65536;
            for (int c = 0; c < 8; c++) foreach (raws[j]) put(3'(c), raws[j]);
            $display("test record %0d done", k);
        end
        report_and_stop();
    end
endmodule // testbench

// file: common/aiparam_map.svh
`ifndef AIPARAM_MAP_SVH
`define AIPARAM_MAP_SVH

// Record byte positions
`define REC_UNIT_IDX      4'h0
`define REC_REJ_IDX       4'h1
`define REC_MODE_IDX      4'h2
`define REC_TC_IDX        4'ha
`define REC_LAST_IDX      4'hd
`define REC_ALL_GOT       14'h3fff

// Power-on record, bytes 13..0: unit Celsius, 60 ms, every channel +/-10 V
`define REC_DEFAULT       112'h0000_0000_1919_1919_1919_1919_0200

// Temperature unit codes
`define UNIT_C_CODE       8'h00
`define UNIT_F_CODE       8'h08
`define UNIT_K_CODE       8'h10

// Interference suppression codes
`define REJ_60HZ_CODE     8'h01
`define REJ_50HZ_CODE     8'h02

// Measuring type codes (high nibble)
`define TYPE_VOLT         4'h1
`define TYPE_CURR         4'h2
`define TYPE_RES          4'h5
`define TYPE_RTD          4'h9

// Range codes (low nibble)
`define RNG_50MV          4'hb
`define RNG_500MV         4'h3
`define RNG_1V            4'h4
`define RNG_5V            4'h6
`define RNG_1_5V          4'h7
`define RNG_0_10V         4'h8
`define RNG_10V           4'h9
`define RNG_0_20MA        4'h2
`define RNG_4_20MA        4'h3
`define RNG_PM20MA        4'h4
`define RNG_600R          4'h2
`define RNG_6000R         4'h3

// Value word limits, 17-bit signed; clamp words 16-bit
`define VAL_FULL_POS      17'sh0_6c00
`define VAL_OVER_END      17'sh0_7eff
`define VAL_UNDER_BIP     17'sh1_8100
`define VAL_UNDER_UNI     17'sh1_ed00
`define VAL_OVERFLOW      16'h7fff
`define VAL_UNDERFLOW     16'h8000

// Integration timing
`define CLK_KHZ           125000
`define INT_SHORT_MS      50
`define INT_LONG_MS       60

`endif

// file: common/aiparam_pkg.sv
package aiparam_pkg;

    // Record collection states, one-hot
    typedef enum logic [2:0] {
        REC_IDLE  = 3'h1,
        REC_FILL  = 3'h2,
        REC_APPLY = 3'h4
    } rec_state_t;

    // Temperature unit selection
    typedef enum logic [1:0] {
        UNIT_C   = 2'h0,
        UNIT_F   = 2'h1,
        UNIT_K   = 2'h2,
        UNIT_BAD = 2'h3
    } temp_unit_t;

    // Range class decides clamping of the value word
    typedef enum logic [2:0] {
        CLS_OFF  = 3'h0,
        CLS_BIP  = 3'h1,
        CLS_UNI  = 3'h2,
        CLS_RES  = 3'h3,
        CLS_TEMP = 3'h4,
        CLS_BAD  = 3'h5
    } range_cls_t;

    // Per-channel configuration as applied
    typedef struct packed {
        logic [3:0] mtype;
        logic [3:0] mrange;
        logic [3:0] tempco;
    } chan_cfg_t;

    // Raw converter result in value-word units
    typedef struct packed {
        logic [2:0]        chan;
        logic signed [16:0] raw;
    } sample_t;

    // Scaled value word for one channel
    typedef struct packed {
        logic [2:0]  chan;
        logic [15:0] word;
    } scaled_t;

endpackage

// file: hw/analog_input_param_record.sv
`timescale 1ns/1ps
`include "aiparam_map.svh"

// Behaviour
// - Record is fourteen bytes, fixed positions
// - Byte zero picks Celsius, Fahrenheit or Kelvin
// - Byte one picks 60 or 50 Hz rejection
// - Bytes two to nine: channel type and range
// - Bytes ten to thirteen: two tempco nibbles each
// - All-zero mode byte disables the channel
// - Type one is voltage, seven ranges
// - Bipolar maps to -27648..27648, ends -32512/32511
// - Unipolar voltage maps 0..27648, ends -4864/32511
// - Type two is current, three ranges
// - 4 to 20 mA maps 0..27648, same ends
// - Type five is resistance, 600 or 6000 ohm
// - Resistance never negative, overdrive up to 32511
// - Value word: sign, magnitude, three zero bits
// - Power-on default: +/-10 V, 60 ms
// - Beyond overdrive 32767, beyond underdrive -32768

module analog_input_param_record #(
    parameter int unsigned INT_SHORT_CYC = `INT_SHORT_MS * `CLK_KHZ, // 50 ms window
    parameter int unsigned INT_LONG_CYC  = `INT_LONG_MS * `CLK_KHZ   // 60 ms window
) (
    input  wire logic                        clk,          // Module clock, 125 MHz
    input  wire logic                        sys_rst,      // Synchronous reset
    input  wire logic                        rec_wr,       // Record byte write strobe
    input  wire logic [3:0]                  rec_idx,      // Record byte position
    input  wire logic [7:0]                  rec_byte,     // Record byte value
    input  wire logic                        rec_abort,    // Drop a partial record
    output logic                             rec_ready,    // Record port accepts a byte
    output logic                             rec_done,     // Record applied, pulse
    output logic                             rec_err,      // Bad byte position, pulse
    input  wire logic [3:0]                  rd_idx,       // Readback byte position
    output logic [7:0]                       rd_byte,      // Readback of applied record
    output aiparam_pkg::temp_unit_t          temp_unit,    // Selected temperature unit
    output logic                             integ_short,  // 50 ms integration selected
    output aiparam_pkg::chan_cfg_t [7:0]     chan_cfg,     // Applied channel settings
    output logic [7:0]                       cfg_err,      // Channel code not supported
    output logic                             conv_start,   // Integration window start
    output logic [7:0]                       conv_en,      // Channels to convert
    input  wire logic                        sample_valid, // Converter result strobe
    input  wire aiparam_pkg::sample_t        sample,       // Converter result
    output logic [7:0][15:0]                 value_word,   // Value word per channel
    output logic                             value_upd     // A value word written, pulse
);
    import aiparam_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State of the block
    typedef struct packed {
        rec_state_t       st;         // Record collection state
        logic [13:0]      got;        // Bytes received of the pending record
        logic [13:0][7:0] shadow;     // Pending record
        logic [13:0][7:0] active;     // Applied record
        logic [31:0]      int_cnt;    // Integration window counter
        logic             conv_start; // Window start pulse
        logic             rec_done;   // Applied pulse
        logic             rec_err;    // Bad position pulse
        logic [7:0]       rd_byte;    // Readback register
        logic [7:0][15:0] values;     // Latest value words
        logic             value_upd;  // Update pulse
    } core_t;

    core_t          s;            // Registered state
    core_t          next_s;       // Next state
    range_cls_t     cls [8];      // Decoded class per channel
    logic           scaled_valid; // Scaler result strobe
    scaled_t        scaled;       // Scaler result
    logic [31:0]    int_limit;    // Active window length
    logic           smp_ok;       // Sample belongs to an enabled channel

    ////////////////////////////////////////////////////////////////////////////
    // Decode a mode byte into its clamping class
    function automatic range_cls_t class_of(input logic [7:0] mode);
        range_cls_t c;
        c = CLS_BAD;
        if (mode == 8'h00) begin
            c = CLS_OFF;
        end else if (mode[7:4] == `TYPE_VOLT) begin
            if (mode[3:0] == `RNG_50MV || mode[3:0] == `RNG_500MV ||
                mode[3:0] == `RNG_1V || mode[3:0] == `RNG_5V ||
                mode[3:0] == `RNG_10V) begin
                c = CLS_BIP;
            end else if (mode[3:0] == `RNG_1_5V || mode[3:0] == `RNG_0_10V) begin
                c = CLS_UNI;
            end
        end else if (mode[7:4] == `TYPE_CURR) begin
            if (mode[3:0] == `RNG_PM20MA) begin
                c = CLS_BIP;
            end else if (mode[3:0] == `RNG_0_20MA || mode[3:0] == `RNG_4_20MA) begin
                c = CLS_UNI;
            end
        end else if (mode[7:4] == `TYPE_RES) begin
            if (mode[3:0] == `RNG_600R || mode[3:0] == `RNG_6000R) begin
                c = CLS_RES;
            end
        end else if (mode[7:4] == `TYPE_RTD) begin
            c = CLS_TEMP;
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel fields from the applied record
    for (genvar i = 0; i < 8; i++) begin : g_chan
        localparam int MODE_POS = int'(`REC_MODE_IDX) + i;
        localparam int TC_POS   = int'(`REC_TC_IDX) + i / 2;
        assign chan_cfg[i].mtype  = s.active[MODE_POS][7:4];
        assign chan_cfg[i].mrange = s.active[MODE_POS][3:0];
        // Even channel sits in the high nibble of its pair byte
        assign chan_cfg[i].tempco = (i % 2 == 0) ? s.active[TC_POS][7:4]
                                                 : s.active[TC_POS][3:0];
        assign cls[i]     = class_of(s.active[MODE_POS]);
        // Unsupported codes are not converted, so no bogus words reach the host
        assign conv_en[i] = cls[i] != CLS_OFF && cls[i] != CLS_BAD;
        assign cfg_err[i] = cls[i] == CLS_BAD;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Global selections from bytes zero and one
    always_comb begin
        case (s.active[`REC_UNIT_IDX])
            `UNIT_C_CODE: temp_unit = UNIT_C;
            `UNIT_F_CODE: temp_unit = UNIT_F;
            `UNIT_K_CODE: temp_unit = UNIT_K;
            default:      temp_unit = UNIT_BAD;
        endcase
        // Anything but the 60 Hz code keeps the longer, safer window
        integ_short = s.active[`REC_REJ_IDX] == `REJ_60HZ_CODE;
        int_limit   = integ_short ? INT_SHORT_CYC : INT_LONG_CYC;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter results of disabled channels are dropped
    assign smp_ok = sample_valid && conv_en[sample.chan];

    value_scaler u_scaler (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (smp_ok),
        .in        (sample),
        .cls       (cls[sample.chan]),
        .out_valid (scaled_valid),
        .out       (scaled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.conv_start = 1'b0;
        next_s.rec_done   = 1'b0;
        next_s.rec_err    = 1'b0;
        next_s.value_upd  = 1'b0;
        // Readback of the applied record, zero past the last byte
        if (rd_idx <= `REC_LAST_IDX) begin
            next_s.rd_byte = s.active[rd_idx];
        end else begin
            next_s.rd_byte = 8'h00;
        end
        case (s.st)
            REC_IDLE, REC_FILL: begin
                if (rec_abort) begin
                    next_s.got = '0;
                    next_s.st  = REC_IDLE;
                end else if (rec_wr) begin
                    if (rec_idx > `REC_LAST_IDX) begin
                        next_s.rec_err = 1'b1;
                    end else begin
                        next_s.shadow[rec_idx] = rec_byte;
                        next_s.got[rec_idx]    = 1'b1;
                        // Only a complete record moves on to be applied
                        if ((s.got | (14'h0001 << rec_idx)) == `REC_ALL_GOT) begin
                            next_s.st = REC_APPLY;
                        end else begin
                            next_s.st = REC_FILL;
                        end
                    end
                end
            end
            REC_APPLY: begin
                // All channels switch in the same cycle
                next_s.active   = s.shadow;
                next_s.got      = '0;
                next_s.rec_done = 1'b1;
                next_s.st       = REC_IDLE;
            end
            default: begin
                next_s.st = REC_IDLE;
            end
        endcase
        // Integration window; a new record restarts it
        if (s.st == REC_APPLY) begin
            next_s.int_cnt = '0;
        end else if (s.int_cnt >= int_limit - 32'h0000_0001) begin
            next_s.int_cnt    = '0;
            next_s.conv_start = 1'b1;
        end else begin
            next_s.int_cnt = s.int_cnt + 32'h0000_0001;
        end
        // Capture scaled words
        if (scaled_valid) begin
            next_s.values[scaled.chan] = scaled.word;
            next_s.value_upd           = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset loads the power-on record
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s        <= '0;
            s.st     <= REC_IDLE;
            s.active <= `REC_DEFAULT;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rec_ready  = s.st != REC_APPLY;
    assign rec_done   = s.rec_done;
    assign rec_err    = s.rec_err;
    assign rd_byte    = s.rd_byte;
    assign conv_start = s.conv_start;
    assign value_word = s.values;
    assign value_upd  = s.value_upd;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    rec_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        rec_wr && rec_ready && !rec_abort && rec_idx > `REC_LAST_IDX |=> rec_err)
        else $error("write past byte 13 not flagged");
    unit_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        s.active[0] == `UNIT_F_CODE |-> temp_unit == UNIT_F)
        else $error("Fahrenheit code not decoded");
    window_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        s.int_cnt == int_limit - 32'h0000_0001 && s.st != REC_APPLY |=> conv_start)
        else $error("window start missing at end of integration time");
    mode_nib_a: assert property (@(posedge clk) disable iff (sys_rst)
        chan_cfg[7].mtype == s.active[9][7:4] && chan_cfg[3].mrange == s.active[5][3:0])
        else $error("mode byte nibbles misplaced");
    tc_nib_a: assert property (@(posedge clk) disable iff (sys_rst)
        chan_cfg[0].tempco == s.active[10][7:4] && chan_cfg[1].tempco == s.active[10][3:0])
        else $error("tempco nibbles misplaced");
    chan_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        s.active[2] == 8'h00 && sample_valid && sample.chan == 3'h0 |=> !scaled_valid)
        else $error("disabled channel produced a value");
    power_on_a: assert property (@(posedge clk)
        $fell(sys_rst) |-> chan_cfg[5].mtype == `TYPE_VOLT &&
                           chan_cfg[5].mrange == `RNG_10V && !integ_short)
        else $error("power-on default not +/-10 V with 60 ms");
    apply_all_a: assert property (@(posedge clk) disable iff (sys_rst)
        !$stable(s.active) |-> $past(s.st) == REC_APPLY)
        else $error("record applied before all bytes arrived");
    apply_time_a: assert property (@(posedge clk) disable iff (sys_rst)
        s.st == REC_APPLY |=> s.active == $past(s.shadow) && rec_done)
        else $error("complete record not applied");

endmodule // analog_input_param_record

// file: hw/value_scaler.sv
`timescale 1ns/1ps
`include "aiparam_map.svh"

module value_scaler (
    input  wire logic                   clk,       // Module clock
    input  wire logic                   sys_rst,   // Synchronous reset
    input  wire logic                   in_valid,  // Sample strobe
    input  wire aiparam_pkg::sample_t   in,        // Raw sample
    input  wire aiparam_pkg::range_cls_t cls,      // Class of the sample's channel
    output logic                        out_valid, // Scaled value strobe
    output aiparam_pkg::scaled_t        out        // Scaled value word
);
    import aiparam_pkg::*;

    typedef struct packed {
        logic    valid;
        scaled_t val;
    } scaler_t;

    scaler_t s;       // Registered state
    scaler_t next_s;  // Next state

    ////////////////////////////////////////////////////////////////////////////
    // Clamp to the range's limits, then drop the three unused low bits
    always_comb begin
        logic [15:0] masked;
        masked = {in.raw[15:3], 3'b000};
        next_s = s;
        next_s.valid = in_valid;
        next_s.val.chan = in.chan;
        case (cls)
            CLS_BIP: begin
                if (in.raw > `VAL_OVER_END) next_s.val.word = `VAL_OVERFLOW;
                else if (in.raw < `VAL_UNDER_BIP) next_s.val.word = `VAL_UNDERFLOW;
                else next_s.val.word = masked;
            end
            CLS_UNI: begin
                if (in.raw > `VAL_OVER_END) next_s.val.word = `VAL_OVERFLOW;
                else if (in.raw < `VAL_UNDER_UNI) next_s.val.word = `VAL_UNDERFLOW;
                else next_s.val.word = masked;
            end
            CLS_RES: begin
                // Negative resistance is not physical, so it reads as zero
                if (in.raw < 17'sh0_0000) next_s.val.word = 16'h0000;
                else if (in.raw > `VAL_OVER_END) next_s.val.word = `VAL_OVERFLOW;
                else next_s.val.word = masked;
            end
            CLS_TEMP: begin
                // Table ranges live elsewhere; only the 16-bit ends apply here
                if (in.raw > 17'sh0_7fff) next_s.val.word = `VAL_OVERFLOW;
                else if (in.raw < 17'sh1_8000) next_s.val.word = `VAL_UNDERFLOW;
                else next_s.val.word = masked;
            end
            default: begin
                next_s.val.word = 16'h0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_valid = s.valid;
    assign out       = s.val;

    ////////////////////////////////////////////////////////////////////////////
    over_clamp_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_valid && cls == CLS_BIP && in.raw > `VAL_OVER_END |=> out.word == `VAL_OVERFLOW)
        else $error("overdrive beyond end not clamped to 32767");
    res_nonneg_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_valid && cls == CLS_RES |=> !out.word[15])
        else $error("negative value in resistance range");
    low_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
        out_valid && out.word != `VAL_OVERFLOW |-> out.word[2:0] == 3'b000)
        else $error("low three bits of value word not zero");
    bip_full_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_valid && cls == CLS_BIP && in.raw == -`VAL_FULL_POS
        |=> out_valid && out.word == 16'h9400)
        else $error("bipolar negative full scale not -27648");
    uni_under_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_valid && cls == CLS_UNI && in.raw < `VAL_UNDER_UNI |=> out.word == `VAL_UNDERFLOW)
        else $error("unipolar underdrive beyond -4864 not clamped");

endmodule // value_scaler
